// >>> rtl/cfu_pkg.sv
// Purpose: Shared constants and types of the flow control unit.
// Assumes: Word-addressed 16-bit program counter and an 8-bit flag register.
// Notes:   Cycle counts are whole instruction lengths in core clocks.
package cfu_pkg;

   localparam int PC_W     = 16;
   localparam int DATA_W   = 8;
   localparam int RELK_W   = 12;
   localparam int BRK_MSB  = 6;
   localparam int CALK_MSB = 11;
   localparam int BIT_W    = 3;
   localparam int CYC_W    = 3;

   // Flag register bit positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // Instruction lengths in clock cycles.
   localparam logic [CYC_W-1:0] CYC_ONE   = 3'h1;
   localparam logic [CYC_W-1:0] CYC_INDIRECT_JUMP  = 3'h2;
   localparam logic [CYC_W-1:0] CYC_CALL  = 3'h3;
   localparam logic [CYC_W-1:0] CYC_RET   = 3'h4;
   localparam logic [CYC_W-1:0] CYC_SKIP1 = 3'h2;
   localparam logic [CYC_W-1:0] CYC_SKIP2 = 3'h3;
   localparam logic [CYC_W-1:0] CYC_TAKEN = 3'h2;
   localparam logic [CYC_W-1:0] CNT_LAST  = 3'h1;

   // Program counter steps.
   localparam logic [PC_W-1:0] PC_STEP  = 16'h0001;
   localparam logic [PC_W-1:0] PC_SKIP1 = 16'h0002;
   localparam logic [PC_W-1:0] PC_SKIP2 = 16'h0003;

   typedef enum logic [5:0] {
      CFU_INDIRECT_JUMP, CFU_RELATIVE_CALL, CFU_INDIRECT_CALL,
      CFU_POP_PC_FROM_STACK, CFU_POP_PC_AND_UNMASK_IRQ,
      CFU_COMPARE_SKIP_EQUAL, CFU_COMPARE_TWO_REGS, CFU_COMPARE_REGS_WITH_CARRY,
      CFU_COMPARE_REG_IMMEDIATE,
      CFU_SKIP_REG_BIT_CLEAR, CFU_SKIP_REG_BIT_SET,
      CFU_SKIP_IO_BIT_CLEAR, CFU_SKIP_IO_BIT_HIGH,
      CFU_BRANCH_FLAG_SET, CFU_BRANCH_FLAG_CLEAR,
      CFU_BRANCH_ZERO, CFU_BRANCH_NONZERO,
      CFU_BRANCH_CARRY_SET, CFU_BRANCH_CARRY_CLEAR,
      CFU_BRANCH_SAME_HIGHER, CFU_BRANCH_LOWER,
      CFU_BRANCH_NEGATIVE, CFU_BRANCH_POSITIVE,
      CFU_BRANCH_SIGNED_GE, CFU_BRANCH_SIGNED_LT,
      CFU_BRANCH_HALF_CARRY_SET, CFU_BRANCH_HALF_CARRY_CLEAR,
      CFU_BRANCH_TBIT_SET, CFU_BRANCH_TBIT_CLEAR,
      CFU_BRANCH_OVERFLOW_SET, CFU_BRANCH_OVERFLOW_CLEAR
   } cfu_op_t;

   typedef enum logic {
      CFU_IDLE,
      CFU_EXEC
   } cfu_state_t;

   typedef struct packed {
      cfu_state_t              st;
      logic [CYC_W-1:0]        cnt;
      logic                    done;
      logic                    busy;
      logic                    pcLoad;
      logic [PC_W-1:0]         pcNext;
      logic                    pushReturn;
      logic [PC_W-1:0]         returnAddr;
      logic                    popReturn;
      logic                    flagsWrite;
      logic [DATA_W-1:0]       flagsNext;
      logic [CYC_W-1:0]        cycles;
      logic                    pendPush;
      logic                    pendPop;
      logic                    pendFlags;
   } cfu_regs_t;

   localparam cfu_regs_t CFU_REGS_RST = '0;

endpackage

// >>> rtl/cfu_flag_cmp.sv
// Purpose: Subtract-without-store flag generator for the compare group.
// Assumes: Unsigned 8-bit operands, borrow-style carry.
// Notes:   Purely combinational; the caller registers the flags.
`timescale 1ns/1ps
module cfu_flag_cmp (
   input  wire logic [cfu_pkg::DATA_W-1:0] opA,
   input  wire logic [cfu_pkg::DATA_W-1:0] opB,
   input  wire logic                       carryIn,
   input  wire logic                       useCarry,
   output logic                            zeroFlag,
   output logic                            negFlag,
   output logic                            ovfFlag,
   output logic                            carryFlag,
   output logic                            halfFlag
);
   import cfu_pkg::*;

   localparam int SIGN_BIT = DATA_W - 1;
   localparam int HALF_BIT = DATA_W / 2 - 1;

   logic [DATA_W-1:0] diff;
   logic [DATA_W-1:0] borrowIn;

   always_comb begin
      borrowIn  = {{(DATA_W-1){1'b0}}, carryIn & useCarry};
      diff      = DATA_W'(opA - opB - borrowIn);
      zeroFlag  = (diff == '0);
      negFlag   = diff[SIGN_BIT];
      ovfFlag   = (opA[SIGN_BIT] & ~opB[SIGN_BIT] & ~diff[SIGN_BIT])
                | (~opA[SIGN_BIT] & opB[SIGN_BIT] & diff[SIGN_BIT]);
      carryFlag = (~opA[SIGN_BIT] & opB[SIGN_BIT]) | (opB[SIGN_BIT] & diff[SIGN_BIT])
                | (diff[SIGN_BIT] & ~opA[SIGN_BIT]);
      halfFlag  = (~opA[HALF_BIT] & opB[HALF_BIT]) | (opB[HALF_BIT] & diff[HALF_BIT])
                | (diff[HALF_BIT] & ~opA[HALF_BIT]);
   end

endmodule

// >>> rtl/cfu_flow_control_unit.sv
// Purpose: Control-flow executor of an 8-bit core: jumps, calls, returns,
//          compares, skips and flag branches, with per-instruction timing.
// Assumes: The fetch stage presents one decoded operation with its operands
//          on start, and holds the operands steady in that cycle only.
// Notes:   One operation is in flight at a time; start is ignored while busy.
`timescale 1ns/1ps
// Functional notes
// - An indirect jump loads the PC from Z, keeps the flags and lasts 2 cycles.
// - A relative call goes to PC+k+1 and an indirect call to Z, both pushing the return.
// - Compare-skip skips on equal registers, lasting 1, 2 or 3 cycles.
// - The three compares update Z, N, V, C and H without storing, in 1 cycle.
// - Skip on register bit clear skips when the chosen bit is 0, in 1, 2 or 3 cycles.
// - Skip on register bit set skips when the chosen bit is 1, with the same timing.
// - Skip on I/O bit clear skips when the addressed I/O bit is 0, in 1, 2 or 3 cycles.
// - Skip on I/O bit set skips when the addressed I/O bit is 1, with the same timing.
// - Generic branches test flag s set or clear and go to PC+k+1, in 1 or 2 cycles.
// - Carry branches go on C=1 for set and lower, on C=0 for clear and same-or-higher.
// - Signed branches use N xor V: greater-or-equal on 0, less-than on 1.
// - Half-carry branches go on H=1 for the set form and H=0 for the clear form.
// - T branches go on T=1 for the set form and T=0 for the clear form.
// - Overflow branches go on V=1 for the set form and V=0 for the clear form.
module cfu_flow_control_unit (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          start,
   input  wire cfu_pkg::cfu_op_t              opSel,
   input  wire logic [cfu_pkg::PC_W-1:0]      pcIn,
   input  wire logic [cfu_pkg::PC_W-1:0]      zPointer,
   input  wire logic [cfu_pkg::PC_W-1:0]      stackPc,
   input  wire logic [cfu_pkg::DATA_W-1:0]    rdValue,
   input  wire logic [cfu_pkg::DATA_W-1:0]    rrValue,
   input  wire logic [cfu_pkg::DATA_W-1:0]    immValue,
   input  wire logic [cfu_pkg::DATA_W-1:0]    ioValue,
   input  wire logic [cfu_pkg::BIT_W-1:0]     bitSel,
   input  wire logic [cfu_pkg::RELK_W-1:0]    relOffset,
   input  wire logic                          nextIsTwoWord,
   input  wire logic [cfu_pkg::DATA_W-1:0]    flagRegister,
   output logic                               busy,
   output logic                               done,
   output logic                               pcLoad,
   output logic [cfu_pkg::PC_W-1:0]           pcNext,
   output logic                               pushReturn,
   output logic [cfu_pkg::PC_W-1:0]           returnAddr,
   output logic                               popReturn,
   output logic                               flagsWrite,
   output logic [cfu_pkg::DATA_W-1:0]         flagsNext,
   output logic [cfu_pkg::CYC_W-1:0]          cycles
);
   import cfu_pkg::*;

   cfu_regs_t         cur;
   cfu_regs_t         next_cur;
   logic              take;
   logic [PC_W-1:0]   pcPlusOne;
   logic [PC_W-1:0]   brOffset;
   logic [PC_W-1:0]   callOffset;
   logic [PC_W-1:0]   brTarget;
   logic [CYC_W-1:0]  dCyc;
   logic [PC_W-1:0]   dPc;
   logic [DATA_W-1:0] dFlags;
   logic              dPush;
   logic              dPop;
   logic              dFl;
   logic              skipHit;
   logic              brHit;
   logic              cmpZero;
   logic              cmpNeg;
   logic              cmpOvf;
   logic              cmpCarry;
   logic              cmpHalf;
   logic              cmpUseCarry;
   logic [DATA_W-1:0] cmpOperand;

   ////////////////////////////////////////////////////////////////////////////
   // Operand arithmetic.

   assign take        = start & ~cur.busy;
   assign pcPlusOne   = PC_W'(pcIn + PC_STEP);
   assign brOffset    = PC_W'(signed'(relOffset[BRK_MSB:0]));
   assign callOffset  = PC_W'(signed'(relOffset[CALK_MSB:0]));
   assign brTarget    = PC_W'(pcPlusOne + brOffset);
   assign cmpUseCarry = (opSel == CFU_COMPARE_REGS_WITH_CARRY);
   assign cmpOperand  = (opSel == CFU_COMPARE_REG_IMMEDIATE) ? immValue : rrValue;

   cfu_flag_cmp i_cfu_flag_cmp (
      .opA       (rdValue),
      .opB       (cmpOperand),
      .carryIn   (flagRegister[FLAG_C]),
      .useCarry  (cmpUseCarry),
      .zeroFlag  (cmpZero),
      .negFlag   (cmpNeg),
      .ovfFlag   (cmpOvf),
      .carryFlag (cmpCarry),
      .halfFlag  (cmpHalf)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Operation decode: length, next PC, side effects.

   always_comb begin
      dCyc    = CYC_ONE;
      dPc     = pcPlusOne;
      dFlags  = flagRegister;
      dPush   = 1'b0;
      dPop    = 1'b0;
      dFl     = 1'b0;
      skipHit = 1'b0;
      brHit   = 1'b0;
      unique case (opSel)
         CFU_INDIRECT_JUMP: begin
            dCyc = CYC_INDIRECT_JUMP;
            dPc  = zPointer;
         end
         CFU_RELATIVE_CALL: begin
            dCyc  = CYC_CALL;
            dPc   = PC_W'(pcPlusOne + callOffset);
            dPush = 1'b1;
         end
         CFU_INDIRECT_CALL: begin
            dCyc  = CYC_CALL;
            dPc   = zPointer;
            dPush = 1'b1;
         end
         CFU_POP_PC_FROM_STACK: begin
            dCyc = CYC_RET;
            dPc  = stackPc;
            dPop = 1'b1;
         end
         CFU_POP_PC_AND_UNMASK_IRQ: begin
            dCyc           = CYC_RET;
            dPc            = stackPc;
            dPop           = 1'b1;
            dFl            = 1'b1;
            dFlags[FLAG_I] = 1'b1;
         end
         CFU_COMPARE_SKIP_EQUAL: begin
            skipHit = (rdValue == rrValue);
         end
         CFU_COMPARE_TWO_REGS, CFU_COMPARE_REGS_WITH_CARRY, CFU_COMPARE_REG_IMMEDIATE: begin
            dFl            = 1'b1;
            dFlags[FLAG_Z] = cmpZero;
            dFlags[FLAG_N] = cmpNeg;
            dFlags[FLAG_V] = cmpOvf;
            dFlags[FLAG_C] = cmpCarry;
            dFlags[FLAG_H] = cmpHalf;
         end
         CFU_SKIP_REG_BIT_CLEAR: begin
            skipHit = ~rrValue[bitSel];
         end
         CFU_SKIP_REG_BIT_SET: begin
            skipHit = rrValue[bitSel];
         end
         CFU_SKIP_IO_BIT_CLEAR: begin
            skipHit = ~ioValue[bitSel];
         end
         CFU_SKIP_IO_BIT_HIGH: begin
            skipHit = ioValue[bitSel];
         end
         CFU_BRANCH_FLAG_SET: begin
            brHit = flagRegister[bitSel];
         end
         CFU_BRANCH_FLAG_CLEAR: begin
            brHit = ~flagRegister[bitSel];
         end
         CFU_BRANCH_ZERO: begin
            brHit = flagRegister[FLAG_Z];
         end
         CFU_BRANCH_NONZERO: begin
            brHit = ~flagRegister[FLAG_Z];
         end
         CFU_BRANCH_CARRY_SET, CFU_BRANCH_LOWER: begin
            brHit = flagRegister[FLAG_C];
         end
         CFU_BRANCH_CARRY_CLEAR, CFU_BRANCH_SAME_HIGHER: begin
            brHit = ~flagRegister[FLAG_C];
         end
         CFU_BRANCH_NEGATIVE: begin
            brHit = flagRegister[FLAG_N];
         end
         CFU_BRANCH_POSITIVE: begin
            brHit = ~flagRegister[FLAG_N];
         end
         CFU_BRANCH_SIGNED_GE: begin
            brHit = ~(flagRegister[FLAG_N] ^ flagRegister[FLAG_V]);
         end
         CFU_BRANCH_SIGNED_LT: begin
            brHit = flagRegister[FLAG_N] ^ flagRegister[FLAG_V];
         end
         CFU_BRANCH_HALF_CARRY_SET: begin
            brHit = flagRegister[FLAG_H];
         end
         CFU_BRANCH_HALF_CARRY_CLEAR: begin
            brHit = ~flagRegister[FLAG_H];
         end
         CFU_BRANCH_TBIT_SET: begin
            brHit = flagRegister[FLAG_T];
         end
         CFU_BRANCH_TBIT_CLEAR: begin
            brHit = ~flagRegister[FLAG_T];
         end
         CFU_BRANCH_OVERFLOW_SET: begin
            brHit = flagRegister[FLAG_V];
         end
         CFU_BRANCH_OVERFLOW_CLEAR: begin
            brHit = ~flagRegister[FLAG_V];
         end
         default: begin
            dCyc = CYC_ONE;
         end
      endcase
      if (skipHit) begin
         dCyc = nextIsTwoWord ? CYC_SKIP2 : CYC_SKIP1;
         dPc  = PC_W'(pcIn + (nextIsTwoWord ? PC_SKIP2 : PC_SKIP1));
      end
      if (brHit) begin
         dCyc = CYC_TAKEN;
         dPc  = brTarget;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: counts the instruction length, then pulses the results.

   always_comb begin
      next_cur            = cur;
      next_cur.done       = 1'b0;
      next_cur.pcLoad     = 1'b0;
      next_cur.pushReturn = 1'b0;
      next_cur.popReturn  = 1'b0;
      next_cur.flagsWrite = 1'b0;
      unique case (cur.st)
         CFU_IDLE: begin
            if (take) begin
               next_cur.cycles     = dCyc;
               next_cur.pcNext     = dPc;
               next_cur.returnAddr = pcPlusOne;
               next_cur.flagsNext  = dFlags;
               next_cur.pendPush   = dPush;
               next_cur.pendPop    = dPop;
               next_cur.pendFlags  = dFl;
               if (dCyc == CYC_ONE) begin
                  next_cur.done = 1'b1;
               end else begin
                  next_cur.st   = CFU_EXEC;
                  next_cur.busy = 1'b1;
                  next_cur.cnt  = CYC_W'(dCyc - CYC_ONE);
               end
            end
         end
         CFU_EXEC: begin
            next_cur.cnt = CYC_W'(cur.cnt - CYC_ONE);
            if (cur.cnt == CNT_LAST) begin
               next_cur.st   = CFU_IDLE;
               next_cur.busy = 1'b0;
               next_cur.done = 1'b1;
            end
         end
      endcase
      // Side effects leave the block only in the final cycle of the operation.
      if (next_cur.done) begin
         next_cur.pcLoad     = 1'b1;
         next_cur.pushReturn = next_cur.pendPush;
         next_cur.popReturn  = next_cur.pendPop;
         next_cur.flagsWrite = next_cur.pendFlags;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cur <= CFU_REGS_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign busy       = cur.busy;
   assign done       = cur.done;
   assign pcLoad     = cur.pcLoad;
   assign pcNext     = cur.pcNext;
   assign pushReturn = cur.pushReturn;
   assign returnAddr = cur.returnAddr;
   assign popReturn  = cur.popReturn;
   assign flagsWrite = cur.flagsWrite;
   assign flagsNext  = cur.flagsNext;
   assign cycles     = cur.cycles;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_take(cfu_op_t o);
      take && opSel == o;
   endsequence

   sequence s_wait2;
      busy ##1 done;
   endsequence

   sequence s_wait3;
      busy [*2] ##1 done;
   endsequence

   a_indirect_jump_zload:
   assert property (s_take(CFU_INDIRECT_JUMP) |=> s_wait2 ##0
                    (pcLoad && pcNext == $past(zPointer, 2) && !flagsWrite))
      else $error("indirect jump target or timing wrong");

   a_indirect_call_push:
   assert property (s_take(CFU_INDIRECT_CALL) |=> s_wait3 ##0
                    (pushReturn && pcNext == $past(zPointer, 3)
                     && returnAddr == $past(pcIn, 3) + PC_STEP))
      else $error("indirect call push or target wrong");

   a_ret_pop:
   assert property (s_take(CFU_POP_PC_FROM_STACK) |=> busy [*3] ##1
                    (done && popReturn && pcNext == $past(stackPc, 4) && !flagsWrite))
      else $error("return pop timing wrong");

   a_pop_pc_and_unmask_irq_unmask:
   assert property (s_take(CFU_POP_PC_AND_UNMASK_IRQ) |-> ##4
                    (done && flagsWrite && flagsNext[FLAG_I]))
      else $error("interrupt return did not set I");

   a_compare_skip_equal_skip2:
   assert property (s_take(CFU_COMPARE_SKIP_EQUAL) ##0 (rdValue == rrValue && nextIsTwoWord)
                    |=> s_wait3 ##0 (pcNext == $past(pcIn, 3) + PC_SKIP2))
      else $error("compare skip over two words wrong");

   a_cmp_flags:
   assert property (take && opSel == CFU_COMPARE_TWO_REGS |=>
                    done && flagsWrite && flagsNext[FLAG_Z] == ($past(rdValue) == $past(rrValue)))
      else $error("compare flags or timing wrong");

   a_skip_reg_bit_clear_noskip:
   assert property (s_take(CFU_SKIP_REG_BIT_CLEAR) ##0 rrValue[bitSel] |=>
                    done && pcNext == $past(pcIn) + PC_STEP)
      else $error("register bit skip fired wrongly");

   a_skip_io_bit_clear_skip1:
   assert property (s_take(CFU_SKIP_IO_BIT_CLEAR) ##0 (!ioValue[bitSel] && !nextIsTwoWord)
                    |=> s_wait2 ##0 (pcNext == $past(pcIn, 2) + PC_SKIP1))
      else $error("I/O bit skip over one word wrong");

   a_br_taken:
   assert property (s_take(CFU_BRANCH_FLAG_SET) ##0 flagRegister[bitSel] |=> s_wait2 ##0
                    (pcNext == $past(pcIn, 2) + $past(brOffset, 2) + PC_STEP))
      else $error("taken flag branch wrong");

   a_branch_signed_lt_taken:
   assert property (s_take(CFU_BRANCH_SIGNED_LT) ##0
                    (flagRegister[FLAG_N] != flagRegister[FLAG_V]) |-> ##2 done && cycles == CYC_TAKEN)
      else $error("signed branch not taken");

endmodule

// >>> test/cfu_flow_control_unit_tb_top.sv
// Purpose: Self-checking bench of the flow control unit.
// Assumes: Operands are driven with start and held until the next take.
// Notes:   Each scenario measures the done delay from the take edge.
`timescale 1ns/1ps
module cfu_flow_control_unit_tb_top;
   import cfu_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, start = 1'b0, nextIsTwoWord = 1'b0;
   cfu_op_t     opSel = CFU_INDIRECT_JUMP;
   logic [15:0] pcIn = '0, zPointer = '0, stackPc = '0, pcNext, returnAddr;
   logic [7:0]  rdValue = '0, rrValue = '0, immValue = '0, ioValue = '0;
   logic [7:0]  flagRegister = '0, flagsNext;
   logic [2:0]  bitSel = '0, cycles;
   logic [11:0] relOffset = '0;
   logic        busy, done, pcLoad, pushReturn, popReturn, flagsWrite;
   int          failures = 0, checksDone = 0;

   always #2.5 clk = ~clk;

   cfu_flow_control_unit i_cfu_flow_control_unit (
      .clk(clk), .rst_b(rst_b), .start(start), .opSel(opSel), .pcIn(pcIn),
      .zPointer(zPointer), .stackPc(stackPc), .rdValue(rdValue), .rrValue(rrValue),
      .immValue(immValue), .ioValue(ioValue), .bitSel(bitSel), .relOffset(relOffset),
      .nextIsTwoWord(nextIsTwoWord), .flagRegister(flagRegister), .busy(busy),
      .done(done), .pcLoad(pcLoad), .pcNext(pcNext), .pushReturn(pushReturn),
      .returnAddr(returnAddr), .popReturn(popReturn), .flagsWrite(flagsWrite),
      .flagsNext(flagsNext), .cycles(cycles));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checksDone++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Called at a rising edge after the operands were scheduled there.
   task automatic go(input cfu_op_t op, input logic [2:0] expCyc, input logic [15:0] expPc);
      int   n;
      logic isCall, isRet, isFw;
      isCall = op inside {CFU_RELATIVE_CALL, CFU_INDIRECT_CALL};
      isRet  = op inside {CFU_POP_PC_FROM_STACK, CFU_POP_PC_AND_UNMASK_IRQ};
      isFw   = op inside {CFU_COMPARE_TWO_REGS, CFU_COMPARE_REGS_WITH_CARRY,
                          CFU_COMPARE_REG_IMMEDIATE, CFU_POP_PC_AND_UNMASK_IRQ};
      start <= 1'b1;
      opSel <= op;
      @(posedge clk);
      start <= 1'b0;
      // The take edge already launches done for a one-cycle operation.
      n = 1;
      #1;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n), 16'(expCyc), "done delay");
      chk(16'(cycles), 16'(expCyc), "cycle count");
      chk(pcNext, expPc, "next pc");
      chk(16'({pcLoad, pushReturn, popReturn, flagsWrite}),
          16'({1'b1, isCall, isRet, isFw}), "strobes");
      if (!isFw) begin
         chk(16'(flagsNext), 16'(flagRegister), "flags kept");
      end
      @(posedge clk);
      #1;
      chk(16'({done, pcLoad}), 16'h0000, "pulse end");
   endtask

   function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin, input logic [7:0] fl);
      logic [7:0] r;
      logic [7:0] o;
      r = a - b - 8'(cin);
      o = fl;
      o[FLAG_Z] = (r == 8'h00);
      o[FLAG_N] = r[7];
      o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      o[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      return o;
   endfunction

   function automatic logic tk(input cfu_op_t op, input logic [7:0] f, input logic [2:0] s);
      case (op)
         CFU_BRANCH_FLAG_SET:                         return f[s];
         CFU_BRANCH_FLAG_CLEAR:                       return !f[s];
         CFU_BRANCH_ZERO:                             return f[FLAG_Z];
         CFU_BRANCH_NONZERO:                          return !f[FLAG_Z];
         CFU_BRANCH_CARRY_SET, CFU_BRANCH_LOWER:      return f[FLAG_C];
         CFU_BRANCH_CARRY_CLEAR, CFU_BRANCH_SAME_HIGHER: return !f[FLAG_C];
         CFU_BRANCH_NEGATIVE:                         return f[FLAG_N];
         CFU_BRANCH_POSITIVE:                         return !f[FLAG_N];
         CFU_BRANCH_SIGNED_GE:                        return !(f[FLAG_N] ^ f[FLAG_V]);
         CFU_BRANCH_SIGNED_LT:                        return f[FLAG_N] ^ f[FLAG_V];
         CFU_BRANCH_HALF_CARRY_SET:                   return f[FLAG_H];
         CFU_BRANCH_HALF_CARRY_CLEAR:                 return !f[FLAG_H];
         CFU_BRANCH_TBIT_SET:                         return f[FLAG_T];
         CFU_BRANCH_TBIT_CLEAR:                       return !f[FLAG_T];
         CFU_BRANCH_OVERFLOW_SET:                     return f[FLAG_V];
         default:                                     return !f[FLAG_V];
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_flow();
      @(posedge clk);
      zPointer <= 16'h1234;
      pcIn <= 16'h0100;
      relOffset <= 12'h800;
      flagRegister <= 8'h00;
      go(CFU_INDIRECT_JUMP, CYC_INDIRECT_JUMP, 16'h1234);
      @(posedge clk);
      go(CFU_RELATIVE_CALL, CYC_CALL, 16'hf901);
      chk(returnAddr, 16'h0101, "call return address");
      @(posedge clk);
      go(CFU_INDIRECT_CALL, CYC_CALL, 16'h1234);
      chk(returnAddr, 16'h0101, "call return address");
      @(posedge clk);
      stackPc <= 16'hbeef;
      go(CFU_POP_PC_FROM_STACK, CYC_RET, 16'hbeef);
      @(posedge clk);
      go(CFU_POP_PC_AND_UNMASK_IRQ, CYC_RET, 16'hbeef);
      chk(16'(flagsNext), 16'h0080, "interrupt enable set");
   endtask

   task automatic s_compare();
      logic [7:0] tA [4] = '{8'h10, 8'h80, 8'h00, 8'h5a};
      logic [7:0] tB [4] = '{8'h01, 8'h01, 8'h01, 8'h5a};
      cfu_op_t    op;
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 3; m++) begin
            op = (m == 0) ? CFU_COMPARE_TWO_REGS :
                 (m == 1) ? CFU_COMPARE_REGS_WITH_CARRY : CFU_COMPARE_REG_IMMEDIATE;
            @(posedge clk);
            pcIn <= 16'h0300;
            rdValue <= tA[i];
            rrValue <= (m == 2) ? 8'h00 : tB[i];
            immValue <= (m == 2) ? tB[i] : 8'h00;
            flagRegister <= 8'h41;
            go(op, CYC_ONE, 16'h0301);
            chk(16'(flagsNext), 16'(cmpf(tA[i], tB[i], m == 1, 8'h41)), "compare flags");
         end
      end
   endtask

   task automatic s_skips();
      cfu_op_t    ops [5] = '{CFU_COMPARE_SKIP_EQUAL, CFU_SKIP_REG_BIT_CLEAR,
                              CFU_SKIP_REG_BIT_SET, CFU_SKIP_IO_BIT_CLEAR,
                              CFU_SKIP_IO_BIT_HIGH};
      logic       b;
      logic [7:0] v;
      logic [2:0] c;
      for (int o = 0; o < 5; o++) begin
         for (int s = 0; s < 2; s++) begin
            for (int w = 0; w < 2; w++) begin
               b = (o == 2 || o == 4) ? s[0] : !s[0];
               v = {b, {7{~b}}};
               c = (s == 0) ? CYC_ONE : (w == 1) ? CYC_SKIP2 : CYC_SKIP1;
               @(posedge clk);
               pcIn <= 16'hfffe;
               bitSel <= 3'h7;
               nextIsTwoWord <= w[0];
               rdValue <= (o == 0) ? 8'h3c : (o > 2) ? ~v : v;
               rrValue <= (o == 0) ? (s == 1 ? 8'h3c : 8'h3d) : (o > 2) ? ~v : v;
               ioValue <= (o > 2) ? v : ~v;
               go(ops[o], c, 16'hfffe + 16'(c));
            end
         end
      end
   endtask

   task automatic s_branches();
      logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
      cfu_op_t    op;
      logic       t;
      for (int v = int'(CFU_BRANCH_FLAG_SET); v <= int'(CFU_BRANCH_OVERFLOW_CLEAR); v++) begin
         for (int p = 0; p < 4; p++) begin
            op = cfu_op_t'(v);
            t = tk(op, pat[p], 3'h2);
            @(posedge clk);
            pcIn <= 16'h0200;
            relOffset <= 12'hfc0;
            bitSel <= 3'h2;
            flagRegister <= pat[p];
            go(op, t ? CYC_TAKEN : CYC_ONE, t ? 16'h01c1 : 16'h0201);
         end
      end
   endtask

   // A start seen while busy must neither cut the jump short nor run later.
   task automatic s_refuse();
      @(posedge clk);
      opSel <= CFU_INDIRECT_JUMP;
      zPointer <= 16'h2468;
      start <= 1'b1;
      @(posedge clk);
      opSel <= CFU_COMPARE_TWO_REGS;
      @(posedge clk);
      start <= 1'b0;
      #1;
      chk(16'({done, pcLoad, flagsWrite}), 16'h0006, "jump end");
      chk(pcNext, 16'h2468, "jump target kept");
      @(posedge clk);
      #1;
      chk(16'({busy, done}), 16'h0000, "refused start idle");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      s_flow();
      s_compare();
      s_skips();
      s_branches();
      s_refuse();
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule
